// file: shared/adcc_pkg.sv
// adcc_pkg: register map, reset values and cycle counts of the converter control.
// assumes a 40 MHz system clock; every count is in system clock cycles.
`default_nettype none
package adcc_pkg;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFF_CTRL0       = 12'hf70;
    localparam logic [11:0] OFF_CTRL1       = 12'hf74;
    localparam logic [11:0] OFF_STATUS      = 12'hf78;
    localparam logic [11:0] OFF_RESULT      = 12'hf7c;
    // control 0 fields
    localparam int          B_GO            = 7;
    localparam int          B_REF_LO        = 6;
    localparam int          B_REF_DRV       = 5;
    localparam int          B_REPEAT        = 4;
    localparam int          CHAN_MSB        = 3;
    localparam logic [7:0]  CTRL0_RST       = 8'h00;
    // control 1: high reference bit, reset 1 so the default code is 2.0 V
    localparam int          B_REF_HI        = 0;
    localparam logic        REF_HI_RST      = 1'b1;
    // status fields
    localparam int          B_ST_BUSY       = 0;
    localparam int          B_ST_POWERED    = 1;
    localparam int          B_ST_WAKING     = 2;
    // reference codes {hi, lo}
    localparam logic [1:0]  REF_EXTERNAL    = 2'h0;
    localparam logic [1:0]  REF_1V0         = 2'h1;
    localparam logic [1:0]  REF_2V0         = 2'h2;
    localparam logic [1:0]  REF_RESERVED    = 2'h3;
    // cycle counts
    localparam int          FIRST_CYC       = 5129;
    localparam int          UPDATE_CYC      = 256;
    localparam int          IDLE_OFF_CYC    = 160;
    localparam int          WAKE_CYC        = 40;
    localparam int          TMR_W           = 15;
    localparam int          RES_W           = 10;
    typedef enum logic [2:0] {
        ADCC_OFF, ADCC_WAKE, ADCC_IDLE, ADCC_FIRST, ADCC_REPEAT_CONV
    } adcc_state_t;
endpackage
`default_nettype wire

// file: rtl/adcc_timer.sv
// adcc_timer: loadable down counter giving a done pulse n cycles after a load.
// assumes load and run come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module adcc_timer #(
    parameter int W = 15
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    output logic              done
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (run && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
        end
    end

    // done ignores load: the owner decides reloads from done, so a feedback loop is avoided
    assign done = run && (cnt_reg == W'(1));
endmodule
`default_nettype wire

// file: rtl/adcc_avmm_slave.sv
// adcc_avmm_slave: avalon-mm handshake with exactly one wait state per access.
// assumes the master holds address, read/write and data until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module adcc_avmm_slave (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic read,
    input  wire logic write,
    output logic      waitrequest,
    output logic      rd_prep,
    output logic      wr_take
);
    logic ack_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
        end
    end

    assign waitrequest = (read || write) && !ack_reg;
    // read data is captured during the wait cycle so it stands at the accept edge
    assign rd_prep     = read && !ack_reg;
    assign wr_take     = write && ack_reg;

    a_one_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("access not accepted after one wait state");
endmodule
`default_nettype wire

// file: rtl/adcc_conv_ctrl.sv
// adcc_conv_ctrl: conversion control of the on-chip converter behind an avalon-mm slave.
// assumes an analog core that converts the selected channel while powered and
// presents its result on core_result when result_take pulses.
// Notes on behaviour
// RULE1: writing 1 to conv_go starts a conversion on the selected channel.
// RULE2: writing conv_go 1 during a conversion abandons it and restarts from scratch.
// RULE3: conv_go stays 1 for the whole conversion, hardware clears it at the end.
// RULE4: writing conv_go 0 changes nothing in the conversion.
// RULE5: reference code {hi,lo}: 00 external, 01 1.0 V, 10 2.0 V default, 11 reserved.
// RULE6: ref_pin_drive 1 buffers the internal reference onto its pin, 0 frees the pin.
// RULE7: software keeps ref_pin_drive 0 while the external reference is chosen.
// RULE8: single shot gives one result after 5129 cycles.
// RULE9: continuous gives a first result after 5129 cycles, then one every 256.
// RULE10: the temperature sensor channel doubles both the first and update times.
// RULE11: the four-bit channel field selects the analog input of every conversion.
// RULE12: after 160 idle cycles parts of the converter power down.
// RULE13: starting from power-down waits 40 cycles of power-up before converting.
// RULE14: after a single-shot conversion completes, the converter shuts down.
// RULE15: software sets the high reference bit before starting conversions.
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_ctrl
    import adcc_pkg::*;
#(
    parameter int         FIRST_CYCLES = FIRST_CYC,
    parameter logic [3:0] TEMP_CHAN    = 4'hf
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    output logic [3:0]             input_channel_sel,
    output logic [1:0]             ref_level_code,
    output logic                   ref_pin_drive,
    output logic                   adc_power_on,
    output logic                   adc_converting,
    output logic                   result_take,
    input  wire logic [RES_W-1:0]  core_result
);
    logic [7:0]       ctrl0_reg;
    logic             ref_hi_reg;
    logic [RES_W-1:0] result_reg;
    logic [31:0]      readdata_reg;
    logic             result_take_reg;
    adcc_state_t      state_reg;
    adcc_state_t      state_next;
    logic             rd_prep;
    logic             wr_take;
    logic             wr_ctrl0;
    logic             go_write;
    logic             conv_load;
    logic [TMR_W-1:0] conv_len;
    logic             conv_done;
    logic             idle_done;
    logic             in_conv;
    logic             temp_sel;
    logic             finish;

    adcc_avmm_slave u_bus (
        .clock       (clock),
        .rst_n       (rst_n),
        .read        (read),
        .write       (write),
        .waitrequest (waitrequest),
        .rd_prep     (rd_prep),
        .wr_take     (wr_take)
    );

    assign wr_ctrl0 = wr_take && address == OFF_CTRL0 && byteenable[0];
    assign go_write = wr_ctrl0 && writedata[B_GO];
    assign in_conv  = state_reg == ADCC_FIRST || state_reg == ADCC_REPEAT_CONV;
    // a write of a new channel together with go is timed for the new channel
    assign temp_sel = (wr_ctrl0 ? writedata[CHAN_MSB:0] : ctrl0_reg[CHAN_MSB:0])
                    == TEMP_CHAN; // RULE10 RULE11

    // doubled lengths for the temperature sensor; any restart reloads the first length
    always_comb begin
        if (state_reg == ADCC_OFF && go_write) begin
            conv_len = TMR_W'(WAKE_CYC); // RULE13
        end else if (go_write || state_reg == ADCC_WAKE) begin
            conv_len = temp_sel ? TMR_W'(2 * FIRST_CYCLES) : TMR_W'(FIRST_CYCLES); // RULE8 RULE10
        end else begin
            conv_len = temp_sel ? TMR_W'(2 * UPDATE_CYC) : TMR_W'(UPDATE_CYC); // RULE9 RULE10
        end
    end

    // reload on any start, restart, wake finish, or update boundary
    assign conv_load = (go_write && state_reg != ADCC_WAKE)
                     || (state_reg == ADCC_WAKE && conv_done)
                     || (in_conv && conv_done);

    // one timer serves wake, first and update intervals; it runs only while waking or converting, not in idle
    adcc_timer #(.W(TMR_W)) u_conv_tmr (
        .clock    (clock),
        .rst_n    (rst_n),
        .load     (conv_load),
        .load_val (conv_len),
        .run      (state_reg != ADCC_OFF && state_reg != ADCC_IDLE),
        .done     (conv_done)
    );

    adcc_timer #(.W(TMR_W)) u_idle_tmr (
        .clock    (clock),
        .rst_n    (rst_n),
        .load     (state_reg != ADCC_IDLE),
        .load_val (TMR_W'(IDLE_OFF_CYC)),
        .run      (state_reg == ADCC_IDLE && !go_write),
        .done     (idle_done)
    );

    // a result is presented with repeat off; a write of 1 in the same cycle still restarts
    assign finish = in_conv && conv_done && !go_write
                  && !ctrl0_reg[B_REPEAT]; // RULE8

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ADCC_OFF: begin
                if (go_write) begin
                    state_next = ADCC_WAKE; // RULE13
                end
            end
            ADCC_WAKE: begin
                if (conv_done) begin
                    state_next = ADCC_FIRST; // RULE13
                end
            end
            ADCC_IDLE: begin
                if (go_write) begin
                    state_next = ADCC_FIRST; // RULE1
                end else if (idle_done) begin
                    state_next = ADCC_OFF; // RULE12
                end
            end
            ADCC_FIRST, ADCC_REPEAT_CONV: begin
                if (go_write) begin
                    state_next = ADCC_FIRST; // RULE2
                end else if (finish && state_reg == ADCC_FIRST) begin
                    state_next = ADCC_OFF; // RULE14
                end else if (finish) begin
                    state_next = ADCC_IDLE;
                end else if (conv_done) begin
                    state_next = ADCC_REPEAT_CONV; // RULE9
                end
            end
            default: begin
                state_next = ADCC_OFF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ADCC_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // conv_go: write of 1 sets and wins over the hardware clear
    // a write of 0 leaves the bit to hardware, so a clear in that cycle still lands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_reg <= CTRL0_RST;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_reg[6:0] <= writedata[6:0]; // RULE4 RULE11
            end
            if (go_write) begin
                ctrl0_reg[B_GO] <= 1'b1; // RULE1 RULE2
            end else if (finish) begin
                ctrl0_reg[B_GO] <= 1'b0; // RULE3
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_hi_reg <= REF_HI_RST;
        end else if (wr_take && address == OFF_CTRL1 && byteenable[0]) begin
            ref_hi_reg <= writedata[B_REF_HI];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_reg      <= '0;
            result_take_reg <= 1'b0;
        end else begin
            result_take_reg <= in_conv && conv_done && !go_write; // RULE8 RULE9
            if (result_take_reg) begin
                result_reg <= core_result;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_reg <= '0;
        end else if (rd_prep) begin
            if (address == OFF_CTRL0) begin
                readdata_reg <= {24'h000000, ctrl0_reg}; // RULE3
            end else if (address == OFF_CTRL1) begin
                readdata_reg <= {31'h00000000, ref_hi_reg};
            end else if (address == OFF_STATUS) begin
                readdata_reg <= {29'h00000000, state_reg == ADCC_WAKE,
                                 state_reg != ADCC_OFF, ctrl0_reg[B_GO]};
            end else if (address == OFF_RESULT) begin
                readdata_reg <= {{(32 - RES_W){1'b0}}, result_reg};
            end else begin
                readdata_reg <= 32'h00000000;
            end
        end
    end

    // ref pin drive with external reference is software's to avoid
    assign ref_level_code    = {ref_hi_reg, ctrl0_reg[B_REF_LO]}; // RULE5 RULE15
    assign ref_pin_drive     = ctrl0_reg[B_REF_DRV]; // RULE6 RULE7
    assign input_channel_sel = ctrl0_reg[CHAN_MSB:0]; // RULE11
    assign adc_power_on      = state_reg != ADCC_OFF; // RULE12 RULE14
    assign adc_converting    = in_conv;
    assign result_take       = result_take_reg;
    assign readdata          = readdata_reg;

    // checks: cycles since the last timer load, and cycles spent idle
    logic [TMR_W-1:0] age_reg;
    logic [7:0]       idle_age_reg;
    logic [TMR_W-1:0] len_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            age_reg      <= '0;
            len_reg      <= '0;
            idle_age_reg <= '0;
        end else begin
            age_reg      <= conv_load ? '0 : age_reg + TMR_W'(1);
            len_reg      <= conv_load ? conv_len : len_reg;
            idle_age_reg <= state_reg == ADCC_IDLE ? idle_age_reg + 8'h01 : 8'h00;
        end
    end

    sequence s_go_write;
        go_write;
    endsequence

    sequence s_zero_write_busy;
        wr_ctrl0 && !writedata[B_GO] && in_conv && !conv_done;
    endsequence

    a_go_sets: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
        s_go_write |=> ctrl0_reg[B_GO] && state_reg != ADCC_IDLE)
        else $error("conversion not started by go write");
    a_restart_first: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
        s_go_write and in_conv |=> state_reg == ADCC_FIRST && age_reg == '0
            && len_reg == ($past(temp_sel) ? TMR_W'(2 * FIRST_CYCLES) : TMR_W'(FIRST_CYCLES)))
        else $error("running conversion not restarted");
    a_go_held: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
        in_conv |-> ctrl0_reg[B_GO])
        else $error("go bit low during conversion");
    a_zero_noeffect: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        s_zero_write_busy |=> ctrl0_reg[B_GO] && state_reg == $past(state_reg))
        else $error("zero write disturbed conversion");
    a_ref_follows: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
        wr_ctrl0 |=> ref_level_code[0] == $past(writedata[B_REF_LO]))
        else $error("reference low bit not taken");
    a_pin_drive: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
        wr_ctrl0 |=> ref_pin_drive == $past(writedata[B_REF_DRV]))
        else $error("reference pin drive not taken");
    a_result_time: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
        in_conv && conv_done |-> age_reg == len_reg - TMR_W'(1) && len_reg != '0)
        else $error("result at wrong cycle");
    a_update_len: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
        state_reg == ADCC_REPEAT_CONV && conv_load && !go_write && !temp_sel
        |-> conv_len == TMR_W'(UPDATE_CYC))
        else $error("update interval wrong");
    a_temp_double: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
        (state_reg == ADCC_IDLE && go_write || state_reg == ADCC_WAKE && conv_done)
        && temp_sel |-> conv_len == TMR_W'(2 * FIRST_CYCLES))
        else $error("temperature sensor time not doubled");
    a_channel_out: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
        wr_ctrl0 |=> input_channel_sel == $past(writedata[CHAN_MSB:0]))
        else $error("channel not applied");
    a_idle_off: assert property (@(posedge clock) disable iff (!rst_n) // RULE12
        state_reg == ADCC_IDLE |-> idle_age_reg < 8'(IDLE_OFF_CYC))
        else $error("idle converter not powered down");
    a_wake_len: assert property (@(posedge clock) disable iff (!rst_n) // RULE13
        state_reg == ADCC_OFF && go_write |=> state_reg == ADCC_WAKE [*8] ##33 state_reg == ADCC_FIRST)
        else $error("power-up wait not 40 cycles");
    a_single_off: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
        finish && state_reg == ADCC_FIRST |=> state_reg == ADCC_OFF && !ctrl0_reg[B_GO])
        else $error("single shot did not shut down");
    a_go_clears: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
        finish |=> !ctrl0_reg[B_GO])
        else $error("go bit not cleared at end of conversion");
endmodule
`default_nettype wire

// file: verif/adcc_core_model.sv
// adcc_core_model: behavioural analog core feeding core_result to the control block.
// assumes result_take is a one-cycle pulse on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
    import adcc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [3:0]       input_channel_sel,
    input  wire logic [1:0]       ref_level_code,
    input  wire logic             result_take,
    output var  logic [RES_W-1:0] core_result
);
    logic [3:0] cnt_reg;
    logic       phase_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
        end else if (result_take) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // outside a capture the value flips every cycle so a stale sample shows up
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    always_comb begin
        core_result = result_take ? {input_channel_sel, ref_level_code, cnt_reg}
                                  : {RES_W{phase_reg}};
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench: drives the converter control over avalon-mm and times its results.
// assumes adcc_core_model on the core side and a shortened first conversion.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adcc_pkg::*;
;
    localparam int N       = 20;
    localparam int TIMEOUT = 20000;
    logic              clock;
    logic              rst_n;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic [3:0]        input_channel_sel;
    logic [1:0]        ref_level_code;
    logic              ref_pin_drive;
    logic              adc_power_on;
    logic              adc_converting;
    logic              result_take;
    logic [RES_W-1:0]  core_result;
    logic [31:0]       rd;
    logic [1:0]        code;
    int                bad_count;
    int                compares;
    int                ncyc;
    int                takes;
    int                ta;
    int                tb;
    int                t;
    int                tp;

    adcc_conv_ctrl #(.FIRST_CYCLES(N), .TEMP_CHAN(4'hf)) dut (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .input_channel_sel(input_channel_sel),
        .ref_level_code(ref_level_code), .ref_pin_drive(ref_pin_drive),
        .adc_power_on(adc_power_on), .adc_converting(adc_converting),
        .result_take(result_take), .core_result(core_result)
    );
    adcc_core_model core (
        .clock(clock), .rst_n(rst_n), .input_channel_sel(input_channel_sel),
        .ref_level_code(ref_level_code), .result_take(result_take), .core_result(core_result)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // stamps read ncyc only at rising edges, so they never race its update
    always @(negedge clock) begin
        ncyc <= ncyc + 1;
        if (ncyc == TIMEOUT) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic av_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] be,
                         output int ts);
        @(posedge clock);
        address    <= a;
        writedata  <= {24'h0, d};
        byteenable <= be;
        write      <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        ts = ncyc;
        write <= 1'b0;
    endtask

    task automatic av_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read    <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic wait_take(output int ts);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (result_take !== 1'b1 && n < 2000);
        chk(32'(n < 2000), 32'h1);
        ts = ncyc;
        takes++;
    endtask

    initial begin
        rst_n = 1'b0; address = '0; read = 1'b0; write = 1'b0;
        writedata = 32'h0; byteenable = 4'h0;
        bad_count = 0; compares = 0; takes = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // reset values and register access
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h0);
        av_rd(OFF_CTRL1, rd); chk(rd, 32'h1);
        chk(32'(ref_level_code), 32'(REF_2V0));
        chk(32'(ref_pin_drive), 32'h0);
        av_rd(12'h100, rd); chk(rd, 32'h0);
        av_wr(OFF_STATUS, 8'hff, 4'h1, t);
        av_rd(OFF_STATUS, rd); chk(rd, 32'h0);
        av_wr(OFF_CTRL0, 8'h2a, 4'h0, t);
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h0);
        for (int c = 0; c < 4; c++) begin
            code = 2'(c);
            av_wr(OFF_CTRL1, {7'h0, code[1]}, 4'h1, t);
            // external reference keeps the pin driver off
            av_wr(OFF_CTRL0, {1'b0, code[0], code != 2'h0, 1'b0, 4'(c * 5)}, 4'h1, t);
            // outputs settle after the accept edge
            @(negedge clock);
            chk(32'(ref_level_code), 32'(code));
            chk(32'(ref_pin_drive), 32'(code != 2'h0));
            chk(32'(input_channel_sel), 32'(c * 5));
        end
        av_wr(OFF_CTRL1, 8'h01, 4'h1, t);
        av_wr(OFF_CTRL0, 8'h00, 4'h1, t);
        $display("test registers done");
        // single shot from power-down
        av_wr(OFF_CTRL0, 8'h83, 4'h1, ta);
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h83);
        av_rd(OFF_STATUS, rd); chk(rd, 32'h7);
        wait_take(t);
        chk(32'(t - ta), 32'(N + 1 + WAKE_CYC));
        chk(32'(adc_power_on), 32'h0);
        chk(32'(adc_converting), 32'h0);
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h03);
        av_rd(OFF_RESULT, rd); chk(rd, {22'h0, 4'h3, 2'h2, 4'(takes - 1)});
        $display("test single shot done");
        // continuous on the temperature channel, go written 0 in mid-run
        av_wr(OFF_CTRL0, 8'h9f, 4'h1, ta);
        wait_take(t);
        chk(32'(t - ta), 32'(2 * N + 1 + WAKE_CYC));
        av_wr(OFF_CTRL0, 8'h1f, 4'h1, tb);
        tp = t;
        wait_take(t);
        chk(32'(t - tp), 32'(2 * UPDATE_CYC));
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h9f);
        av_wr(OFF_CTRL0, 8'h0f, 4'h1, tb);
        tp = t;
        wait_take(t);
        chk(32'(t - tp), 32'(2 * UPDATE_CYC));
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h0f);
        $display("test continuous temperature done");
        // restart from powered idle
        av_wr(OFF_CTRL0, 8'h81, 4'h1, ta);
        repeat (5) @(posedge clock);
        chk(32'(adc_converting), 32'h1);
        av_wr(OFF_CTRL0, 8'h81, 4'h1, tb);
        wait_take(t);
        chk(32'(t - tb), 32'(N + 1));
        chk(32'(adc_power_on), 32'h0);
        $display("test restart done");
        // continuous, stop, idle power-down
        av_wr(OFF_CTRL0, 8'h92, 4'h1, ta);
        wait_take(t);
        chk(32'(t - ta), 32'(N + 1 + WAKE_CYC));
        tp = t;
        wait_take(t);
        chk(32'(t - tp), 32'(UPDATE_CYC));
        av_rd(OFF_RESULT, rd); chk(rd, {22'h0, 4'h2, 2'h2, 4'(takes - 1)});
        av_wr(OFF_CTRL0, 8'h02, 4'h1, tb);
        tp = t;
        wait_take(t);
        chk(32'(t - tp), 32'(UPDATE_CYC));
        av_rd(OFF_CTRL0, rd); chk(rd, 32'h02);
        chk(32'(adc_power_on), 32'h1);
        while (adc_power_on !== 1'b0 && ncyc - t < 400) @(posedge clock);
        chk(32'(ncyc - t), 32'(IDLE_OFF_CYC));
        $display("test power-down done");
        print_verdict();
    end
endmodule
`default_nettype wire
